// >>> rtl/hcsl_top.sv
// Implementation choices: the address map and register access over Wishbone.
`timescale 1ns/1ns
`include "hcsl_params.svh"

// Function
// - Data bit 3 enables automatic receive squelch polarity switching.
// - Address bit 1 low restricts reconnection to good transmitted packets.
// - Address bit 2 picks 63 (low) or 31 (high) collisions to partition.
// - Address bit 3 picks minimum (low) or maximum (high) LED mode.
// - Data bits 0,1 and address bit 4 are ignored at capture.
// - Strobe pulses to latch presented pin values in both modes.
// - Minimum mode drives collision, receive, jabber, partition on data pins 0..3.
// - Minimum mode leaves address pins with no LED meaning.
// - Maximum mode puts data on data pins and address bit 0, address on 1..4.
// - Maximum mode address counts 0 to 9 then wraps, pin 1 is LSB.
// - Maximum data active high; address 0 global, 1 uplink, 2..9 ports.
// - Optional mode captures pin levels at rising edge of selected reset.
// - Source select high uses defaults, low uses strapped values.
// - Pins are released while the register access path uses them.
module hcsl_top #(
  parameter int STROBE_CYC = `HCSL_STROBE_CYC       // Strobe low width in cycles
) (
  input  wire logic       i_mclk,                  // 50 MHz clock
  input  wire logic       i_reset_n,               // Synchronous reset, active low
  input  wire logic       i_ce,                    // Clock enable
  input  wire logic       i_external_reset_n,      // External reset pin
  input  wire logic       i_reset_ext_sel,         // 1 selects external reset
  input  wire logic       i_config_source_sel,     // 1 default, 0 strapped
  input  wire logic       i_host_access,           // Register access owns pins
  input  wire logic [3:0] i_data_pins,             // Data pin levels
  input  wire logic [4:0] i_reg_addr_pins,         // Address pin levels
  output logic      [3:0] o_data_pins,             // Data pin drive
  output logic      [3:0] o_data_pins_oe,          // Data pin enable
  output logic      [4:0] o_reg_addr_pins,         // Address pin drive
  output logic      [4:0] o_reg_addr_pins_oe,      // Address pin enable
  output logic            o_led_latch_strobe_n,    // LED latch strobe
  input  wire logic       i_any_collision,         // Collision on any port
  input  wire logic       i_any_receive,           // Receive on any port
  input  wire logic       i_jabber_protect,        // Jabber protect state
  input  wire logic       i_any_partition,         // Any port partitioned
  input  wire logic [2:0] i_uplink_status,         // Uplink col, rec, part
  input  wire logic [7:0] i_port_link,             // Port link ok
  input  wire logic [7:0] i_port_coll,             // Port collision
  input  wire logic [7:0] i_port_recv,             // Port receive
  input  wire logic [7:0] i_port_part,             // Port partition
  input  wire logic [7:0] i_port_bad_polarity,     // Port bad polarity
  output logic            o_rx_polarity_auto_switch, // Polarity switch enable
  output logic            o_reconnect_on_tx_only_n,  // Reconnect on tx only, low
  output logic      [6:0] o_collision_limit,       // Consecutive collision limit
  output logic            o_max_led_mode,          // 1 maximum LED mode
  input  wire logic [7:0] i_wb_adr,                // Wishbone address
  input  wire logic [31:0] i_wb_dat,               // Wishbone write data
  input  wire logic [3:0] i_wb_sel,                // Wishbone byte select
  input  wire logic       i_wb_we,                 // Wishbone write
  input  wire logic       i_wb_cyc,                // Wishbone cycle
  input  wire logic       i_wb_stb,                // Wishbone strobe
  output logic      [31:0] o_wb_dat,               // Wishbone read data
  output logic            o_wb_ack,                // Wishbone acknowledge
  output logic            o_irq                    // Level interrupt
);
  import hcsl_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  hcsl_led_state_t state_q;
  logic [3:0]  cfg_q;
  logic        strap_err_q;
  logic        rst_src_q;
  logic        rst_rise;
  logic [3:0]  addr_q;
  logic [7:0]  cnt_q;
  logic [3:0]  data_q;
  logic [4:0]  ra_q;
  logic        str_n_q;
  logic        led_en_q;
  logic [4:0]  frame;
  logic [3:0]  glob;
  logic [3:0]  glob_q;
  logic [3:0]  irq_stat_q;
  logic [3:0]  irq_mask_q;
  logic [3:0]  ev;
  logic        wb_hit;
  logic        wb_wr;
  logic        wr_irq;
  logic [31:0] rd_d;

  assign glob     = {i_any_partition, i_jabber_protect, i_any_receive, i_any_collision};
  assign rst_rise = i_reset_ext_sel ? (i_external_reset_n & ~rst_src_q) : 1'b0;
  assign wb_hit   = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wb_wr    = wb_hit & i_wb_we & i_wb_sel[0];
  assign wr_irq   = wb_wr & (i_wb_adr == `HCSL_OFS_IRQ_STAT);

  // ----------------------------------------------------------------
  // Configuration capture
  // ----------------------------------------------------------------
  // Previous level of external reset, for rising edge detection
  // Resets to the idle high level so no false capture follows reset
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      rst_src_q <= 1'b1;
    end else if (i_ce) begin
      rst_src_q <= i_external_reset_n;
    end
  end

  // Configuration capture at internal reset release or external rising edge
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      cfg_q       <= `HCSL_CFG_DEFAULT;
      strap_err_q <= 1'b0;
    end else if (i_ce && (rst_rise || (!i_reset_ext_sel && state_q == HCSL_SETUP
                                       && !led_en_q))) begin
      if (i_config_source_sel) begin
        cfg_q       <= `HCSL_CFG_DEFAULT;
        strap_err_q <= 1'b0;
      end else begin
        cfg_q       <= {i_reg_addr_pins[3:1], i_data_pins[3]};
        strap_err_q <= ~(i_data_pins[2] & i_reg_addr_pins[0]);
      end
    end
  end

  assign o_rx_polarity_auto_switch = cfg_q[`HCSL_CFG_POL_BIT];
  assign o_reconnect_on_tx_only_n  = cfg_q[`HCSL_CFG_TXO_BIT];
  assign o_collision_limit = cfg_q[`HCSL_CFG_CCL_BIT] ? `HCSL_COLL_LIMIT_HI
                                                      : `HCSL_COLL_LIMIT_LO;
  assign o_max_led_mode    = cfg_q[`HCSL_CFG_MAX_BIT];

  // ----------------------------------------------------------------
  // LED output sequencer
  // ----------------------------------------------------------------
  hcsl_led_frame u_frame (
    .i_addr    (addr_q),
    .i_global  (glob),
    .i_uplink  (i_uplink_status),
    .i_link    (i_port_link),
    .i_coll    (i_port_coll),
    .i_recv    (i_port_recv),
    .i_part    (i_port_part),
    .i_bad_pol (i_port_bad_polarity),
    .o_data    (frame)
  );

  // Setup data, pulse strobe, hold, then advance the address in maximum mode or keep it at 0 in minimum mode
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      state_q  <= HCSL_SETUP;
      addr_q   <= 4'h0;
      cnt_q    <= 8'h00;
      data_q   <= 4'h0;
      ra_q     <= 5'h00;
      str_n_q  <= 1'b1;
      led_en_q <= 1'b0;
    end else if (i_ce) begin
      unique case (state_q)
        HCSL_SETUP: begin
          led_en_q <= 1'b1;
          if (!i_host_access) begin
            if (cfg_q[`HCSL_CFG_MAX_BIT]) begin
              data_q <= frame[3:0];
              ra_q   <= {addr_q, frame[4]};
            end else begin
              data_q <= glob;
              ra_q   <= 5'h00;
            end
            state_q <= HCSL_STROBE;
          end
        end
        HCSL_STROBE: begin
          str_n_q <= 1'b0;
          cnt_q   <= 8'h00;
          state_q <= HCSL_HOLD;
        end
        HCSL_HOLD: begin
          if (cnt_q == 8'(STROBE_CYC - 1)) begin
            str_n_q <= 1'b1;
            state_q <= HCSL_NEXT;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
        end
        HCSL_NEXT: begin
          if (!cfg_q[`HCSL_CFG_MAX_BIT] || addr_q == `HCSL_LAST_ADDR) begin
            addr_q <= 4'h0;
          end else begin
            addr_q <= addr_q + 4'h1;
          end
          state_q <= HCSL_SETUP;
        end
      endcase
    end
  end

  assign o_data_pins          = data_q;
  assign o_reg_addr_pins      = ra_q;
  assign o_data_pins_oe       = {4{led_en_q & ~i_host_access}};
  assign o_reg_addr_pins_oe   = {5{led_en_q & ~i_host_access
                                   & cfg_q[`HCSL_CFG_MAX_BIT]}};
  assign o_led_latch_strobe_n = str_n_q;

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Rising edge of each global flag is an event
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      glob_q <= 4'h0;
    end else if (i_ce) begin
      glob_q <= glob;
    end
  end

  assign ev = glob & ~glob_q;

  // Sticky status, write one to clear, set wins over clear
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      irq_stat_q <= 4'h0;
    end else if (i_ce) begin
      irq_stat_q <= (irq_stat_q & ~(wr_irq ? i_wb_dat[3:0] : 4'h0)) | ev;
    end
  end

  assign o_irq = |(irq_stat_q & irq_mask_q);

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Mask register write
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      irq_mask_q <= 4'h0;
    end else if (i_ce && wb_wr && i_wb_adr == `HCSL_OFS_IRQ_MASK) begin
      irq_mask_q <= i_wb_dat[3:0];
    end
  end

  // Read multiplexer, unmapped reads return zero
  always_comb begin
    rd_d = 32'h0000_0000;
    case (i_wb_adr)
      `HCSL_OFS_CFG:      rd_d = {27'h0, strap_err_q, cfg_q};
      `HCSL_OFS_STATUS:   rd_d = {24'h0, addr_q, glob};
      `HCSL_OFS_IRQ_STAT: rd_d = {28'h0, irq_stat_q};
      `HCSL_OFS_IRQ_MASK: rd_d = {28'h0, irq_mask_q};
      default:            rd_d = 32'h0000_0000;
    endcase
  end

  // One cycle acknowledge with registered read data
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else if (i_ce) begin
      o_wb_ack <= wb_hit;
      if (wb_hit) begin
        o_wb_dat <= rd_d;
      end
    end
  end
endmodule

// >>> rtl/hcsl_params.svh
`ifndef HCSL_PARAMS_SVH
`define HCSL_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the Wishbone slave)
// ----------------------------------------------------------------
`define HCSL_OFS_CFG      8'h00
`define HCSL_OFS_STATUS   8'h04
`define HCSL_OFS_IRQ_STAT 8'h08
`define HCSL_OFS_IRQ_MASK 8'h0C
`define HCSL_OFS_CTRL     8'h10

// ----------------------------------------------------------------
// Configuration field positions in the captured word
// ----------------------------------------------------------------
`define HCSL_CFG_POL_BIT   0
`define HCSL_CFG_TXO_BIT   1
`define HCSL_CFG_CCL_BIT   2
`define HCSL_CFG_MAX_BIT   3
`define HCSL_CFG_RSV_BIT   4
`define HCSL_CFG_DEFAULT   4'hB

// ----------------------------------------------------------------
// Collision limits and timing
// ----------------------------------------------------------------
`define HCSL_COLL_LIMIT_LO  7'h3F
`define HCSL_COLL_LIMIT_HI  7'h1F
`define HCSL_STROBE_NS      100
`define HCSL_CLK_NS         20
`define HCSL_STROBE_CYC     ((`HCSL_STROBE_NS + `HCSL_CLK_NS - 1) / `HCSL_CLK_NS)
`define HCSL_LAST_ADDR      4'h9

`endif

// >>> rtl/hcsl_pkg.sv
package hcsl_pkg;
  // LED output sequencing states
  typedef enum logic [3:0] {
    HCSL_SETUP  = 4'h1,
    HCSL_STROBE = 4'h2,
    HCSL_HOLD   = 4'h4,
    HCSL_NEXT   = 4'h8
  } hcsl_led_state_t;
endpackage

// >>> rtl/hcsl_led_frame.sv
`timescale 1ns/1ns
`include "hcsl_params.svh"

// Builds one five-bit LED data word for a given latch address
module hcsl_led_frame (
  input  wire logic [3:0] i_addr,       // Latch address 0..9
  input  wire logic [3:0] i_global,     // Any col, rec, jabber, part
  input  wire logic [2:0] i_uplink,     // Uplink col, rec, part
  input  wire logic [7:0] i_link,       // Per port link
  input  wire logic [7:0] i_coll,       // Per port collision
  input  wire logic [7:0] i_recv,       // Per port receive
  input  wire logic [7:0] i_part,       // Per port partition
  input  wire logic [7:0] i_bad_pol,    // Per port bad polarity
  output logic      [4:0] o_data        // {addr0 pin, data pins 3..0}
);
  logic [2:0] port_idx;

  assign port_idx = 3'(i_addr - 4'h2);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  // Active high data per latch address
  always_comb begin
    o_data = 5'h00;
    if (i_addr == 4'h0) begin
      o_data = {1'b0, i_global};
    end else if (i_addr == 4'h1) begin
      o_data = {1'b0, i_uplink, 1'b0};
    end else if (i_addr <= `HCSL_LAST_ADDR) begin
      o_data = {i_bad_pol[port_idx], i_part[port_idx], i_recv[port_idx],
                i_coll[port_idx], i_link[port_idx]};
    end
  end
endmodule

// >>> verification/hcsl_sva.sv
`timescale 1ns/1ns
// Watches LED port timing, config hold and bus answers
module hcsl_sva #(
  parameter int STROBE_CYC = 5  // Strobe low cycles
) (
  input wire logic       i_mclk,                    // Clock
  input wire logic       i_reset_n,                 // Reset, low
  input wire logic       i_external_reset_n,        // External reset
  input wire logic       i_host_access,             // Host owns pins
  input wire logic       i_wb_cyc,                  // Bus cycle
  input wire logic       i_wb_stb,                  // Bus strobe
  input wire logic       o_wb_ack,                  // Bus ack
  input wire logic [3:0] o_data_pins,               // Data drive
  input wire logic [3:0] o_data_pins_oe,            // Data enable
  input wire logic [4:0] o_reg_addr_pins,           // Address drive
  input wire logic [4:0] o_reg_addr_pins_oe,        // Address enable
  input wire logic       o_led_latch_strobe_n,      // Strobe
  input wire logic       o_rx_polarity_auto_switch, // Config
  input wire logic       o_reconnect_on_tx_only_n,  // Config
  input wire logic [6:0] o_collision_limit,         // Config
  input wire logic       o_max_led_mode             // Config
);
  logic [7:0] low_q;
  logic [3:0] quiet_q;
  logic [3:0] last_q;
  logic       ext_q;
  logic       seen_q;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // Length of the current strobe pulse
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || o_led_latch_strobe_n) begin
      low_q <= 8'h00;
    end else begin
      low_q <= low_q + 8'h01;
    end
  end
  // Cycles since the last reset or external reset change
  always_ff @(posedge i_mclk) begin
    ext_q <= i_external_reset_n;
    if (!i_reset_n || ext_q != i_external_reset_n) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hF) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  // Last address latched in maximum mode, forgotten around captures
  always_ff @(posedge i_mclk) begin
    if (!i_reset_n || quiet_q != 4'hF) begin
      seen_q <= 1'b0;
      last_q <= 4'h0;
    end else if ($rose(o_led_latch_strobe_n)) begin
      seen_q <= o_max_led_mode;
      last_q <= o_reg_addr_pins[4:1];
    end
  end
  sequence s_req;
    i_wb_cyc && i_wb_stb && !o_wb_ack;
  endsequence
  sequence s_ack;
    o_wb_ack ##1 !o_wb_ack;
  endsequence
  a_strobe_width: assert property ($rose(o_led_latch_strobe_n) |-> low_q == STROBE_CYC)
    else $error("strobe width wrong");
  a_data_stable: assert property (!o_led_latch_strobe_n |-> $stable(o_data_pins)
    && $stable(o_reg_addr_pins)) else $error("pins moved during strobe");
  a_host_release: assert property (i_host_access |-> o_data_pins_oe == 4'h0
    && o_reg_addr_pins_oe == 5'h00) else $error("pins driven during host access");
  a_min_addr_off: assert property (!o_max_led_mode |-> o_reg_addr_pins_oe == 5'h00)
    else $error("address pins driven in minimum mode");
  a_max_drive: assert property (o_max_led_mode && !o_led_latch_strobe_n && !i_host_access
    |-> o_reg_addr_pins_oe == 5'h1F && o_data_pins_oe == 4'hF)
    else $error("maximum mode pins not driven");
  a_addr_step: assert property ($fell(o_led_latch_strobe_n) && seen_q && o_max_led_mode
    |-> o_reg_addr_pins[4:1] == ((last_q == 4'h9) ? 4'h0 : last_q + 4'h1))
    else $error("latch address out of order");
  a_cfg_hold: assert property (quiet_q == 4'hF |-> $stable({o_rx_polarity_auto_switch,
    o_reconnect_on_tx_only_n, o_collision_limit, o_max_led_mode}))
    else $error("config changed without capture");
  a_ack_timing: assert property (s_req |=> s_ack)
    else $error("bus answer late or long");
endmodule

bind hcsl_top hcsl_sva #(.STROBE_CYC(STROBE_CYC)) u_sva (.*);

// >>> verification/hcsl_latch_model.sv
`timescale 1ns/1ns
// Edge latch for minimum mode and addressable latches for maximum mode
module hcsl_latch_model (
  input  wire logic       i_strobe_n,   // Latch strobe, active low
  input  wire logic [3:0] i_data,       // Data pin levels
  input  wire logic [4:0] i_ra,         // Address pin levels
  output logic      [3:0] o_min_q,      // Minimum mode contents
  output logic      [4:0] o_led_q [10], // Maximum mode contents
  output int              o_steps       // Strobe pulses seen
);
  initial o_steps = 0;
  // Capture at pulse end; the latches only listen, never drive the pins
  always @(posedge i_strobe_n) begin
    o_min_q <= i_data;
    if (i_ra[4:1] < 4'hA)
      o_led_q[i_ra[4:1]] <= {i_ra[0], i_data};
    o_steps <= o_steps + 1;
  end
endmodule

// >>> verification/test_hcsl_top.sv
`timescale 1ns/1ns
// Self-checking bench for config capture and LED output
module test_hcsl_top;
  logic        i_mclk, i_reset_n, i_ce, i_external_reset_n, i_reset_ext_sel;
  logic        i_config_source_sel, i_host_access, i_wb_we, i_wb_cyc, i_wb_stb;
  logic        i_any_collision, i_any_receive, i_jabber_protect, i_any_partition;
  logic        o_led_latch_strobe_n, o_rx_polarity_auto_switch, o_reconnect_on_tx_only_n;
  logic        o_max_led_mode, o_wb_ack, o_irq;
  logic [2:0]  i_uplink_status;
  logic [3:0]  i_data_pins, o_data_pins, o_data_pins_oe, i_wb_sel, strap_d, flg, min_q;
  logic [4:0]  i_reg_addr_pins, o_reg_addr_pins, o_reg_addr_pins_oe, strap_ra;
  logic [4:0]  led_q [10];
  logic [6:0]  o_collision_limit;
  logic [7:0]  i_port_link, i_port_coll, i_port_recv, i_port_part, i_port_bad_polarity;
  logic [7:0]  i_wb_adr;
  logic [9:0]  cfg_o;
  logic [31:0] i_wb_dat, o_wb_dat, rd;
  int          num_errors, tests_run, steps, cyc_n;
  // Pins show the drive where enabled, the strap resistor elsewhere
  assign i_data_pins = (o_data_pins & o_data_pins_oe) | (strap_d & ~o_data_pins_oe);
  assign i_reg_addr_pins = (o_reg_addr_pins & o_reg_addr_pins_oe)
                         | (strap_ra & ~o_reg_addr_pins_oe);
  assign {i_any_partition, i_jabber_protect, i_any_receive, i_any_collision} = flg;
  assign cfg_o = {o_rx_polarity_auto_switch, o_reconnect_on_tx_only_n, o_collision_limit,
                  o_max_led_mode};
  hcsl_top #(.STROBE_CYC(1)) DUT (.*);
  hcsl_latch_model u_leds (.i_strobe_n(o_led_latch_strobe_n), .i_data(i_data_pins),
    .i_ra(i_reg_addr_pins), .o_min_q(min_q), .o_led_q(led_q), .o_steps(steps));
  // Clock
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  // Hang guard
  always @(posedge i_mclk) begin
    cyc_n++;
    if (cyc_n > 5000) begin
      num_errors++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge i_mclk);
    {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'b11, we, adr, dat};
    @(posedge i_mclk);
    while (o_wb_ack !== 1'b1) @(posedge i_mclk);
    rd = o_wb_dat;
    {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'b000;
  endtask
  task automatic wait_str(input int n);
    int s;
    s = steps;
    while (steps < s + n) @(posedge i_mclk);
  endtask
  task automatic do_reset(input logic src, input logic [3:0] d, input logic [4:0] ra);
    @(posedge i_mclk);
    {i_config_source_sel, i_reset_ext_sel, strap_d, strap_ra} <= {src, 1'b0, d, ra};
    i_reset_n <= 1'b0;
    repeat (4) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (6) @(posedge i_mclk);
  endtask
  task automatic t_strap();
    do_reset(1'b0, 4'h7, 5'h15);
    chk("strap cfg", {2'b00, 7'h1F, 1'b0}, cfg_o);
    wb(1'b0, 8'h00, 32'h0);
    chk("cfg reg", 32'h04, rd);
    {strap_d, strap_ra} <= {4'h8, 5'h0E};
    repeat (20) @(posedge i_mclk);
    chk("cfg held", {2'b00, 7'h1F, 1'b0}, cfg_o);
  endtask
  task automatic t_min();
    for (int f = 0; f < 16; f++) begin
      flg <= f[3:0];
      wait_str(2);
      chk("min latch", {5'h00, f[3:0]}, {o_reg_addr_pins_oe, min_q});
    end
  endtask
  task automatic t_ext();
    {i_host_access, i_reset_ext_sel} <= 2'b11;
    @(posedge i_mclk);
    chk("pins released", 9'h000, {o_data_pins_oe, o_reg_addr_pins_oe});
    i_external_reset_n <= 1'b0;
    repeat (3) @(posedge i_mclk);
    i_external_reset_n <= 1'b1;
    repeat (6) @(posedge i_mclk);
    i_host_access <= 1'b0;
    chk("ext cfg", {2'b11, 7'h1F, 1'b1}, cfg_o);
    wb(1'b0, 8'h00, 32'h0);
    chk("strap error", 32'h1F, rd);
  endtask
  task automatic t_default();
    do_reset(1'b1, 4'h0, 5'h00);
    chk("default cfg", {2'b11, 7'h3F, 1'b1}, cfg_o);
  endtask
  task automatic t_max();
    logic [4:0] e;
    int         p;
    {i_port_link, i_port_coll, i_port_recv, i_port_part, i_port_bad_polarity}
      <= 40'hA53C0FF096;
    {i_uplink_status, flg} <= {3'b101, 4'h6};
    wait_str(12);
    for (int a = 0; a < 10; a++) begin
      p = a - 2;
      if (a == 0) e = 5'h06;
      else if (a == 1) e = 5'h0A;
      else e = {i_port_bad_polarity[p], i_port_part[p], i_port_recv[p],
                i_port_coll[p], i_port_link[p]};
      chk("max latch", e, led_q[a]);
    end
  endtask
  task automatic t_irq();
    flg <= 4'h0;
    wb(1'b1, 8'h08, 32'hF);
    wb(1'b1, 8'h0C, 32'h1);
    flg <= 4'h1;
    repeat (3) @(posedge i_mclk);
    chk("irq raised", 1'b1, o_irq);
    wb(1'b0, 8'h08, 32'h0);
    chk("irq status", 32'h1, rd);
    wb(1'b1, 8'h0C, 32'h0);
    chk("irq masked", 1'b0, o_irq);
    wb(1'b1, 8'h0C, 32'h1);
    wb(1'b1, 8'h08, 32'h1);
    chk("irq cleared", 1'b0, o_irq);
    wb(1'b0, 8'h04, 32'h0);
    chk("status flags", 4'h1, rd[3:0]);
    wb(1'b1, 8'h14, 32'hF);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask
  // Main sequence
  initial begin
    {i_reset_n, i_ce, i_external_reset_n, i_reset_ext_sel, i_host_access} = 5'b01100;
    {i_config_source_sel, i_wb_we, i_wb_cyc, i_wb_stb, i_wb_sel} = 8'h0F;
    {i_wb_adr, i_wb_dat, flg, strap_d, strap_ra, i_uplink_status} = 56'h0;
    {i_port_link, i_port_coll, i_port_recv, i_port_part, i_port_bad_polarity} = 40'h0;
    t_strap();
    t_min();
    t_ext();
    t_default();
    t_max();
    t_irq();
    close_out();
  end
endmodule
